/* File: pinmux_pkg.sv */
// Constants shared by the upper pin multiplexer and its register file.
// Assumes a 32-bit APB slave decode with word offsets chosen for this block.
package pinmux_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register word offsets
  localparam logic [ADDR_W-1:0] OFS_PIN_CONFIG_ONE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PIN_CONFIG_TWO = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PIN_DIRECTION = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PIN_VALUE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_ONLY_VALUE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PRINTER_PATTERN = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SCANNER_PATTERN = 8'h18;

  typedef enum logic [2:0] {
    REG_CFG1 = 3'h0,
    REG_CFG2 = 3'h1,
    REG_DIR = 3'h2,
    REG_VAL = 3'h3,
    REG_GPO = 3'h4,
    REG_PM = 3'h5,
    REG_SM = 3'h6,
    REG_NONE = 3'h7
  } reg_sel_type;

  // Pin counts
  localparam int unsigned GPIO_N = 15;
  localparam int unsigned GPIO_FIRST = 16;
  localparam int unsigned GPO_N = 18;
  localparam int unsigned GPI_N = 4;
  localparam int unsigned CFG_W = 16;

  // Configuration one fields
  localparam int unsigned CFG1_PRINTER_GPO = 0;
  localparam int unsigned CFG1_SCANNER_GPO = 1;
  // Configuration two fields
  localparam int unsigned CFG2_SERIAL2 = 0;
  localparam int unsigned CFG2_GPO_HI = 1;
  localparam int unsigned CFG2_CHIP_SEL = 5;
  localparam int unsigned CFG2_ADC = 6;
  localparam int unsigned CFG2_GPIO_HI = 8;

  // Output-only value register fields
  localparam int unsigned GPO_DATA_W = 10;
  localparam int unsigned GPOD_PPORT_LSB = 0;
  localparam int unsigned GPOD_HI_LSB = 6;
  localparam int unsigned GPOD_GPI_LSB = 12;

  // Pin indices relative to the first upper GPIO line
  localparam int unsigned IDX_TX_IN = 0;
  localparam int unsigned IDX_CLK_IN = 1;
  localparam int unsigned IDX_RX_OUT = 2;
  localparam int unsigned IDX_SCK = 3;
  localparam int unsigned IDX_STROBE = 4;
  localparam int unsigned IDX_CTL_IN = 5;
  localparam int unsigned IDX_IRQ = 3;
  localparam int unsigned IDX_CS = 4;
  localparam int unsigned IDX_ADC = 6;
  localparam int unsigned IDX_PDATA = 7;

  localparam int unsigned MOTOR_W = 4;
  localparam int unsigned PCTL_W = 6;
  localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;

endpackage : pinmux_pkg

/* File: pin_sync.sv */
// Two-flop synchroniser bank for pin levels entering the system clock.
// Assumes inputs are asynchronous to CLK_SYS; only the second stage is read.
`timescale 1ns/1ns
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_type;

  sync_state_type state_ff;
  sync_state_type nxt_state;

  always_comb begin
    nxt_state.meta = async_in;
    nxt_state.stable = state_ff.meta;
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sync_out = state_ff.stable;

endmodule : pin_sync

/* File: upper_pin_mux.sv */
// Pin multiplexer for GPIO16..30, GPO0..17 and GPI0..3 with an APB register file.
// Assumes alternate peripherals and the modem side controller share CLK_SYS.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ns
//
// Behaviour
// - Modem mode high: six modem signals on GPIO16..21 in order.
// - Routed modem signals go to data interface if select 0, voice if 1.
// - Modem mode low and config two bit 5: chip select drives GPIO20.
// - Modem mode low: GPIO19 pin level is the active-low modem interrupt.
// - Config two bit 6 puts ADC sample strobe on GPIO22, else GPIO.
// - GPIO22 direction and value from bit 22 of direction and value.
// - Config two bit 8: GPIO23..30 are GPIO, else parallel data 0..7.
// - GPIO23..30 direction and value from bits 30..23.
// - Config one bit 0: GPO0..3 on printer pins, else printer phases.
// - GPO0..3 follow printer pattern low nibble after a write.
// - Config one bit 1: GPO4..7 on scanner pins, else scanner phases.
// - GPO4..7 follow scanner pattern low nibble after a write.
// - Config two bit 8: parallel control pins become GPO8..13, else parallel.
// - GPO8..13 values from output-only value bits 5..0.
// - GPO17..14 shared with analog odd 3, even 3, odd 2, even 2.
// - GPO14..17 values from output-only value bits 9..6.
// - Parallel unused: GPI0..3 pin levels read in output-only bits 15..12.
module upper_pin_mux (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [pinmux_pkg::ADDR_W-1:0] PADDR,
  input wire logic [pinmux_pkg::DATA_W-1:0] PWDATA,
  output logic [pinmux_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [pinmux_pkg::GPIO_N-1:0] GPIO_I,
  output logic [pinmux_pkg::GPIO_N-1:0] GPIO_O,
  output logic [pinmux_pkg::GPIO_N-1:0] GPIO_OE,
  output logic [pinmux_pkg::GPO_N-1:0] GPO_O,
  input wire logic [pinmux_pkg::GPI_N-1:0] GPI_I,
  input wire logic EXT_MODEM_IF_MODE,
  input wire logic EXT_MODEM_IF_VOICE_SEL,
  input wire logic [2:0] DATA_IA_OUT,
  input wire logic [2:0] VOICE_IA_OUT,
  output logic [2:0] DATA_IA_IN,
  output logic [2:0] VOICE_IA_IN,
  input wire logic MODEM_CHIP_SELECT_N,
  output logic MODEM_IRQ_N,
  input wire logic EXT_ADC_SAMPLE_STROBE,
  input wire logic [7:0] PARALLEL_PORT_DATA_O,
  input wire logic [7:0] PARALLEL_PORT_DATA_OE,
  output logic [7:0] PARALLEL_PORT_DATA_I,
  input wire logic [pinmux_pkg::PCTL_W-1:0] PARALLEL_CTL_O,
  output logic [pinmux_pkg::GPI_N-1:0] PARALLEL_STATUS_I,
  input wire logic [pinmux_pkg::MOTOR_W-1:0] PRINTER_MOTOR_PHASE,
  input wire logic [pinmux_pkg::MOTOR_W-1:0] SCANNER_MOTOR_PHASE,
  input wire logic [1:0] ANALOG_ODD_LINE,
  input wire logic [1:0] ANALOG_EVEN_LINE,
  input wire logic SECONDARY_SERIAL_TXD,
  input wire logic SECONDARY_SERIAL_STATUS
);
  import pinmux_pkg::*;

  typedef struct packed {
    logic [CFG_W-1:0] cfg1;
    logic [CFG_W-1:0] cfg2;
    logic [GPIO_N-1:0] dir;
    logic [GPIO_N-1:0] val;
    logic [GPO_DATA_W-1:0] gpo_data;
    logic [MOTOR_W-1:0] pm_pat;
    logic [MOTOR_W-1:0] sm_pat;
    logic [DATA_W-1:0] rdata;
    logic [GPIO_N-1:0] gpio_o;
    logic [GPIO_N-1:0] gpio_oe;
    logic [GPO_N-1:0] gpo_o;
    logic [7:0] pdata_i;
    logic [2:0] data_ia_in;
    logic [2:0] voice_ia_in;
    logic irq_n;
    logic [GPI_N-1:0] pstat;
  } state_type;

  state_type state_ff;
  state_type nxt_state;
  logic [GPIO_N-1:0] gpio_sync;
  logic [GPI_N-1:0] gpi_sync;
  logic setup_phase;
  logic access_phase;
  reg_sel_type acc_sel;

  // Pin levels are asynchronous; every reader sees only the second stage
  pin_sync #(
    .WIDTH(GPIO_N + GPI_N)
  ) u_pin_sync (
    .CLK_SYS(CLK_SYS),
    .RST(RST),
    .async_in({GPI_I, GPIO_I}),
    .sync_out({gpi_sync, gpio_sync})
  );

  function automatic reg_sel_type decode(input logic [ADDR_W-1:0] addr);
    case (addr)
      OFS_PIN_CONFIG_ONE: decode = REG_CFG1;
      OFS_PIN_CONFIG_TWO: decode = REG_CFG2;
      OFS_PIN_DIRECTION: decode = REG_DIR;
      OFS_PIN_VALUE: decode = REG_VAL;
      OFS_OUTPUT_ONLY_VALUE: decode = REG_GPO;
      OFS_PRINTER_PATTERN: decode = REG_PM;
      OFS_SCANNER_PATTERN: decode = REG_SM;
      default: decode = REG_NONE;
    endcase
  endfunction : decode

  assign setup_phase = PSEL && !PENABLE;
  assign access_phase = PSEL && PENABLE;
  assign acc_sel = decode(PADDR);

  always_comb begin
    logic [GPIO_N-1:0] pin_read;
    logic parallel_unused;
    logic [2:0] ia_out;
    nxt_state = state_ff;
    parallel_unused = state_ff.cfg2[CFG2_GPIO_HI];
    ia_out = EXT_MODEM_IF_VOICE_SEL ? VOICE_IA_OUT : DATA_IA_OUT;
    // Lines with their direction bit set read back the value register, others their pin level
    pin_read = (state_ff.dir & state_ff.val) | (~state_ff.dir & gpio_sync);

    // Register writes land at the access edge; zero wait states
    if (access_phase && PWRITE) begin
      case (acc_sel)
        REG_CFG1: nxt_state.cfg1 = PWDATA[CFG_W-1:0];
        REG_CFG2: nxt_state.cfg2 = PWDATA[CFG_W-1:0];
        REG_DIR: nxt_state.dir = PWDATA[GPIO_FIRST +: GPIO_N];
        REG_VAL: nxt_state.val = PWDATA[GPIO_FIRST +: GPIO_N];
        REG_GPO: nxt_state.gpo_data = PWDATA[GPO_DATA_W-1:0];
        REG_PM: nxt_state.pm_pat = PWDATA[MOTOR_W-1:0];
        REG_SM: nxt_state.sm_pat = PWDATA[MOTOR_W-1:0];
        default: nxt_state.cfg1 = state_ff.cfg1;
      endcase
    end

    // Read data is captured in the setup cycle so PRDATA comes from a flop
    if (setup_phase) begin
      nxt_state.rdata = '0;
      case (acc_sel)
        REG_CFG1: nxt_state.rdata[CFG_W-1:0] = state_ff.cfg1;
        REG_CFG2: nxt_state.rdata[CFG_W-1:0] = state_ff.cfg2;
        REG_DIR: nxt_state.rdata[GPIO_FIRST +: GPIO_N] = state_ff.dir;
        REG_VAL: nxt_state.rdata[GPIO_FIRST +: GPIO_N] = pin_read;
        REG_GPO: begin
          nxt_state.rdata[GPO_DATA_W-1:0] = state_ff.gpo_data;
          if (parallel_unused) begin
            nxt_state.rdata[GPOD_GPI_LSB +: GPI_N] = gpi_sync;
          end
        end
        REG_PM: nxt_state.rdata[MOTOR_W-1:0] = state_ff.pm_pat;
        REG_SM: nxt_state.rdata[MOTOR_W-1:0] = state_ff.sm_pat;
        default: nxt_state.rdata = '0;
      endcase
    end

    // Upper GPIO lines default to the direction and value registers
    nxt_state.gpio_oe = state_ff.dir;
    nxt_state.gpio_o = state_ff.val;

    if (state_ff.cfg2[CFG2_ADC]) begin
      nxt_state.gpio_oe[IDX_ADC] = 1'b1;
      nxt_state.gpio_o[IDX_ADC] = EXT_ADC_SAMPLE_STROBE;
    end

    if (!parallel_unused) begin
      nxt_state.gpio_oe[IDX_PDATA +: 8] = PARALLEL_PORT_DATA_OE;
      nxt_state.gpio_o[IDX_PDATA +: 8] = PARALLEL_PORT_DATA_O;
    end

    if (EXT_MODEM_IF_MODE) begin
      nxt_state.gpio_oe[IDX_TX_IN] = 1'b0;
      nxt_state.gpio_oe[IDX_CLK_IN] = 1'b0;
      nxt_state.gpio_oe[IDX_CTL_IN] = 1'b0;
      nxt_state.gpio_oe[IDX_RX_OUT] = 1'b1;
      nxt_state.gpio_oe[IDX_SCK] = 1'b1;
      nxt_state.gpio_oe[IDX_STROBE] = 1'b1;
      nxt_state.gpio_o[IDX_RX_OUT] = ia_out[0];
      nxt_state.gpio_o[IDX_SCK] = ia_out[1];
      nxt_state.gpio_o[IDX_STROBE] = ia_out[2];
    end else if (state_ff.cfg2[CFG2_CHIP_SEL]) begin
      nxt_state.gpio_oe[IDX_CS] = 1'b1;
      nxt_state.gpio_o[IDX_CS] = MODEM_CHIP_SELECT_N;
    end

    // Unselected interface sees idle zeros
    nxt_state.data_ia_in = '0;
    nxt_state.voice_ia_in = '0;
    if (EXT_MODEM_IF_MODE && !EXT_MODEM_IF_VOICE_SEL) begin
      nxt_state.data_ia_in = {gpio_sync[IDX_CTL_IN], gpio_sync[IDX_CLK_IN], gpio_sync[IDX_TX_IN]};
    end
    if (EXT_MODEM_IF_MODE && EXT_MODEM_IF_VOICE_SEL) begin
      nxt_state.voice_ia_in = {gpio_sync[IDX_CTL_IN], gpio_sync[IDX_CLK_IN], gpio_sync[IDX_TX_IN]};
    end

    // Interrupt idles inactive while the pin carries the modem clock
    nxt_state.irq_n = EXT_MODEM_IF_MODE ? 1'b1 : gpio_sync[IDX_IRQ];
    nxt_state.pdata_i = parallel_unused ? 8'h00 : gpio_sync[IDX_PDATA +: 8];
    nxt_state.pstat = gpi_sync;

    // Output-only pins
    nxt_state.gpo_o[3:0] = state_ff.cfg1[CFG1_PRINTER_GPO] ? state_ff.pm_pat : PRINTER_MOTOR_PHASE;
    nxt_state.gpo_o[7:4] = state_ff.cfg1[CFG1_SCANNER_GPO] ? state_ff.sm_pat : SCANNER_MOTOR_PHASE;
    nxt_state.gpo_o[13:8] = parallel_unused ? state_ff.gpo_data[GPOD_PPORT_LSB +: PCTL_W]
                                            : PARALLEL_CTL_O;
    // Analog pairs: GPO17 odd3, GPO16 even3, GPO15 odd2, GPO14 even2
    nxt_state.gpo_o[17:14] = {ANALOG_ODD_LINE[1], ANALOG_EVEN_LINE[1],
                              ANALOG_ODD_LINE[0], ANALOG_EVEN_LINE[0]};
    if (state_ff.cfg2[CFG2_SERIAL2]) begin
      nxt_state.gpo_o[14] = SECONDARY_SERIAL_TXD;
      nxt_state.gpo_o[15] = SECONDARY_SERIAL_STATUS;
    end else if (state_ff.cfg2[CFG2_GPO_HI]) begin
      nxt_state.gpo_o[17:14] = state_ff.gpo_data[GPOD_HI_LSB +: 4];
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign PRDATA = state_ff.rdata;
  assign PREADY = 1'b1;
  assign PSLVERR = access_phase && (acc_sel == REG_NONE);
  assign GPIO_O = state_ff.gpio_o;
  assign GPIO_OE = state_ff.gpio_oe;
  assign GPO_O = state_ff.gpo_o;
  assign DATA_IA_IN = state_ff.data_ia_in;
  assign VOICE_IA_IN = state_ff.voice_ia_in;
  assign MODEM_IRQ_N = state_ff.irq_n;
  assign PARALLEL_PORT_DATA_I = state_ff.pdata_i;
  assign PARALLEL_STATUS_I = state_ff.pstat;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  a_modem_pin_dir: assert property (EXT_MODEM_IF_MODE |=> GPIO_OE[5:0] == 6'b011100)
    else $error("modem pin directions wrong");
  a_voice_route: assert property (EXT_MODEM_IF_MODE && EXT_MODEM_IF_VOICE_SEL
      |=> GPIO_O[4:2] == $past(VOICE_IA_OUT) && DATA_IA_IN == 3'h0)
    else $error("voice interface not routed");
  a_gpio_follow: assert property (!EXT_MODEM_IF_MODE
      |=> GPIO_OE[2:0] == $past(state_ff.dir[2:0]) && GPIO_O[2:0] == $past(state_ff.val[2:0]))
    else $error("GPIO16..18 do not follow registers");
  a_chip_select: assert property (!EXT_MODEM_IF_MODE && state_ff.cfg2[CFG2_CHIP_SEL]
      |=> GPIO_OE[IDX_CS] && GPIO_O[IDX_CS] == $past(MODEM_CHIP_SELECT_N))
    else $error("chip select not on GPIO20");
  a_irq_level: assert property (!EXT_MODEM_IF_MODE ##1 !EXT_MODEM_IF_MODE
      |=> MODEM_IRQ_N == $past(GPIO_I[IDX_IRQ], 3))
    else $error("modem interrupt not from GPIO19");
  a_adc_pin: assert property (state_ff.cfg2[CFG2_ADC]
      |=> GPIO_OE[IDX_ADC] && GPIO_O[IDX_ADC] == $past(EXT_ADC_SAMPLE_STROBE))
    else $error("ADC strobe not on GPIO22");
  a_pio_data: assert property (!state_ff.cfg2[CFG2_GPIO_HI]
      |=> GPIO_O[14:7] == $past(PARALLEL_PORT_DATA_O) && GPO_O[13:8] == $past(PARALLEL_CTL_O))
    else $error("parallel port not on pins");
  a_printer_gpo: assert property (access_phase && PWRITE && acc_sel == REG_PM && state_ff.cfg1[CFG1_PRINTER_GPO]
      ##1 state_ff.cfg1[CFG1_PRINTER_GPO] |=> GPO_O[3:0] == $past(PWDATA[3:0], 2))
    else $error("printer pattern not on GPO0..3");
  a_gpo_hi: assert property (!state_ff.cfg2[CFG2_SERIAL2] && state_ff.cfg2[CFG2_GPO_HI]
      |=> GPO_O[17:14] == $past(state_ff.gpo_data[9:6]))
    else $error("GPO14..17 not from value bits");
  a_gpi_read: assert property (setup_phase && acc_sel == REG_GPO && state_ff.cfg2[CFG2_GPIO_HI]
      |=> PRDATA[15:12] == $past(gpi_sync))
    else $error("GPI levels not read back");
  // Alternate sources reach the pads one edge after the select is seen
  a_data_route: assert property (EXT_MODEM_IF_MODE && !EXT_MODEM_IF_VOICE_SEL
      |=> GPIO_O[4:2] == $past(DATA_IA_OUT) && VOICE_IA_IN == 3'h0)
    else $error("data interface not routed");
  a_gpio_hi: assert property (state_ff.cfg2[CFG2_GPIO_HI]
      |=> GPIO_OE[14:7] == $past(state_ff.dir[14:7]) && GPIO_O[14:7] == $past(state_ff.val[14:7]))
    else $error("GPIO23..30 do not follow registers");
  a_printer_phase: assert property (!state_ff.cfg1[CFG1_PRINTER_GPO]
      |=> GPO_O[3:0] == $past(PRINTER_MOTOR_PHASE))
    else $error("printer phases not on GPO0..3");
  a_scanner_phase: assert property (!state_ff.cfg1[CFG1_SCANNER_GPO]
      |=> GPO_O[7:4] == $past(SCANNER_MOTOR_PHASE))
    else $error("scanner phases not on GPO4..7");
  a_pctl_gpo: assert property (state_ff.cfg2[CFG2_GPIO_HI]
      |=> GPO_O[13:8] == $past(state_ff.gpo_data[5:0]))
    else $error("GPO8..13 not from value bits");
  a_analog_pins: assert property (!state_ff.cfg2[CFG2_SERIAL2] && !state_ff.cfg2[CFG2_GPO_HI]
      |=> GPO_O[17:14] == $past({ANALOG_ODD_LINE[1], ANALOG_EVEN_LINE[1],
                                 ANALOG_ODD_LINE[0], ANALOG_EVEN_LINE[0]}))
    else $error("analog lines not on GPO14..17");
  a_serial_pins: assert property (state_ff.cfg2[CFG2_SERIAL2]
      |=> GPO_O[14] == $past(SECONDARY_SERIAL_TXD) && GPO_O[15] == $past(SECONDARY_SERIAL_STATUS))
    else $error("secondary serial not on GPO14/15");

  c_modem_voice: cover property (EXT_MODEM_IF_MODE && EXT_MODEM_IF_VOICE_SEL ##1 !EXT_MODEM_IF_MODE);
  c_serial_pins: cover property (state_ff.cfg2[CFG2_SERIAL2] && state_ff.cfg1[CFG1_SCANNER_GPO]);
  c_bad_address: cover property (PSLVERR);
  c_modem_data: cover property (EXT_MODEM_IF_MODE && !EXT_MODEM_IF_VOICE_SEL);
  c_gpio_read: cover property (setup_phase && acc_sel == REG_VAL);

endmodule : upper_pin_mux

/* File: pin_far_model.sv */
// Far-side pads of the upper GPIO lines: resolves each wire level.
// Assumes the bench supplies what outside parts drive onto released pins.
`timescale 1ns/1ns
module pin_far_model (
  input wire logic [14:0] gpio_o,
  input wire logic [14:0] gpio_oe,
  input wire logic [14:0] ext_gpio,
  output logic [14:0] gpio_i
);
  // Device drive wins; a released pin shows the outside driver, never a stale level
  always_comb begin
    for (int i = 0; i < 15; i++) begin
      gpio_i[i] = gpio_oe[i] ? gpio_o[i] : ext_gpio[i];
    end
  end
endmodule : pin_far_model

/* File: test_gpio_gpo_gpi_pin_multiplexer.sv */
// Self-checking bench for the upper pin multiplexer over APB.
// Assumes zero-wait APB slave and pin_far_model on the GPIO pads.
`timescale 1ns/1ns
module test_gpio_gpo_gpi_pin_multiplexer;
  import pinmux_pkg::*;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, pd_o, pd_oe, pd_i;
  logic [31:0] pwdata, prdata, rd;
  logic [14:0] gio_i, gio_o, gio_oe, ext;
  logic [17:0] gpo;
  logic [3:0] gpi, pm, sm, pst;
  logic mode, vsel, cs_n, adc, irq_n, txd, sta;
  logic [2:0] d_out, v_out, d_in, v_in;
  logic [5:0] pctl;
  logic [1:0] ao, ae;
  int errors, compares, cycles;

  upper_pin_mux dut (.CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .GPIO_I(gio_i), .GPIO_O(gio_o), .GPIO_OE(gio_oe), .GPO_O(gpo), .GPI_I(gpi),
    .EXT_MODEM_IF_MODE(mode), .EXT_MODEM_IF_VOICE_SEL(vsel), .DATA_IA_OUT(d_out),
    .VOICE_IA_OUT(v_out), .DATA_IA_IN(d_in), .VOICE_IA_IN(v_in), .MODEM_CHIP_SELECT_N(cs_n),
    .MODEM_IRQ_N(irq_n), .EXT_ADC_SAMPLE_STROBE(adc), .PARALLEL_PORT_DATA_O(pd_o),
    .PARALLEL_PORT_DATA_OE(pd_oe), .PARALLEL_PORT_DATA_I(pd_i), .PARALLEL_CTL_O(pctl),
    .PARALLEL_STATUS_I(pst), .PRINTER_MOTOR_PHASE(pm), .SCANNER_MOTOR_PHASE(sm),
    .ANALOG_ODD_LINE(ao), .ANALOG_EVEN_LINE(ae), .SECONDARY_SERIAL_TXD(txd),
    .SECONDARY_SERIAL_STATUS(sta));
  pin_far_model pads (.gpio_o(gio_o), .gpio_oe(gio_oe), .ext_gpio(ext), .gpio_i(gio_i));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task report_and_stop;
    $display("Comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // Ceiling well above the hundred or so cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      report_and_stop();
    end
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Pin inputs need three edges through the synchroniser and output flop
  task settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle

  initial begin
    {psel, penable, pwrite, paddr, pwdata, gpi, mode, vsel, d_out, v_out} = '0;
    {cs_n, adc, pd_o, pd_oe, pctl, pm, sm, ao, ae, txd, sta, ext} = '0;
    rst = 1'b1;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, OFS_PIN_CONFIG_ONE, 32'h0);
    check("cfg1 reset", rd, 32'h0);
    check("pready", pready, 1'b1);
    pm <= 4'h9;
    sm <= 4'h6;
    pctl <= 6'h2d;
    ae <= 2'b01;
    ao <= 2'b10;
    pd_o <= 8'hc3;
    pd_oe <= 8'h0f;
    ext <= 15'h2a80;
    settle(4);
    check("motor phases", gpo[7:0], 8'h69);
    check("parallel ctl", gpo[13:8], 6'h2d);
    check("analog", gpo[17:14], 4'b1001);
    check("pdata out", {gio_oe[14:7], gio_o[14:7]}, 16'h0fc3);
    check("pdata in", pd_i, 8'h53);
    check("irq low", irq_n, 1'b0);
    $display("test defaults done");
    apb(1'b1, OFS_PIN_CONFIG_ONE, 32'h3);
    apb(1'b1, OFS_PRINTER_PATTERN, 32'hfa);
    apb(1'b1, OFS_SCANNER_PATTERN, 32'h35);
    settle(2);
    check("motor gpo", gpo[7:0], 8'h5a);
    $display("test motor done");
    apb(1'b1, OFS_PIN_CONFIG_TWO, 32'h102);
    apb(1'b1, OFS_OUTPUT_ONLY_VALUE, 32'h3a5);
    gpi <= 4'hb;
    txd <= 1'b1;
    settle(4);
    check("gpo 17..8", gpo[17:8], 10'h3a5);
    check("parallel status", pst, 4'hb);
    apb(1'b0, OFS_OUTPUT_ONLY_VALUE, 32'h0);
    check("gpi read", rd, 32'hb3a5);
    apb(1'b1, OFS_PIN_CONFIG_TWO, 32'h103);
    settle(2);
    check("serial2", gpo[15:14], 2'b01);
    $display("test gpo done");
    apb(1'b1, OFS_PIN_CONFIG_TWO, 32'h100);
    apb(1'b1, OFS_PIN_DIRECTION, 32'h7fff0000);
    apb(1'b1, OFS_PIN_VALUE, 32'h2aaa0000);
    cs_n <= 1'b1;
    adc <= 1'b1;
    settle(2);
    check("gpio drive", {1'b0, gio_oe, 1'b0, gio_o}, 32'h7fff2aaa);
    apb(1'b1, OFS_PIN_CONFIG_TWO, 32'h160);
    settle(2);
    check("cs adc", {gio_oe[6], gio_oe[4], gio_o[6], gio_o[4]}, 4'hf);
    apb(1'b1, OFS_PIN_CONFIG_TWO, 32'h100);
    apb(1'b1, OFS_PIN_DIRECTION, 32'h0);
    ext <= 15'h2a88;
    settle(4);
    apb(1'b0, OFS_PIN_VALUE, 32'h0);
    check("gpio read", rd, 32'h2a880000);
    check("irq high", irq_n, 1'b1);
    $display("test gpio done");
    mode <= 1'b1;
    d_out <= 3'b110;
    v_out <= 3'b001;
    ext <= 15'h0021;
    settle(4);
    check("modem pins", {gio_oe[5:0], gio_o[4:2]}, 9'h0e6);
    check("data ia in", {d_in, v_in}, 6'h28);
    check("irq modem", irq_n, 1'b1);
    @(posedge clk_sys);
    vsel <= 1'b1;
    settle(4);
    check("voice pins", gio_o[4:2], 3'b001);
    check("voice ia in", {d_in, v_in}, 6'h05);
    $display("test modem done");
    apb(1'b1, 8'h40, 32'hffff);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped error", er, 1'b1);
    check("unmapped read", rd, 32'h0);
    $display("test unmapped done");
    report_and_stop();
  end
endmodule : test_gpio_gpo_gpi_pin_multiplexer
